//--- core/swwd_defines.svh
// Timing, width and ratio constants of the supervisor window watchdog
`ifndef SWWD_DEFINES_SVH
`define SWWD_DEFINES_SVH

`define SWWD_CLK_MHZ         200
`define SWWD_TICK_NS         1000
`define SWWD_TICK_CYCLES     (`SWWD_TICK_NS * `SWWD_CLK_MHZ / 1000)
`define SWWD_GLITCH_NS       3000
`define SWWD_GLITCH_CYCLES   ((`SWWD_GLITCH_NS * `SWWD_CLK_MHZ + 999) / 1000)
`define SWWD_US_TO_TICKS(t)  ((t) / (`SWWD_TICK_NS / 1000))
`define SWWD_RELEASE_US      25000
`define SWWD_TIMEOUT_LO_US   250000
`define SWWD_TIMEOUT_HI_US   2500000
`define SWWD_CAP_STEP_US     6250

`define SWWD_TW              26
`define SWWD_CAPW            12
`define SWWD_RECIPW          12
`define SWWD_RECIP_SHIFT     16
`define SWWD_RECIP(r)        ((655360 + (r) / 2) / (r))
`define SWWD_RATIO_NARROW_LO 318
`define SWWD_RATIO_NARROW_HI 320
`define SWWD_RATIO_NARROW_CP 258
`define SWWD_RATIO_WIDE_LO   1249
`define SWWD_RATIO_WIDE_HI   1277
`define SWWD_RATIO_WIDE_CP   645

`endif

//--- core/swwd_link_if.sv
// Time base and filtered undervoltage carried to the watchdog core
`timescale 1ns/1ps
interface swwd_link_if;
  logic tick;
  logic uv_flt;
  modport timebase (output tick);
  modport filter   (output uv_flt);
  modport core     (input tick, input uv_flt);
endinterface

//--- core/swwd_pkg.sv
// Types shared by the supervisor window watchdog modules
package swwd_pkg;
  typedef enum logic [0:0] {
    SWWD_ST_RESET = 1'b0,
    SWWD_ST_RUN   = 1'b1
  } swwd_state_type;
  typedef logic [25:0] swwd_ticks_type;
endpackage

//--- core/swwd_timebase.sv
// One-cycle tick each microsecond from the free-running clock
`timescale 1ns/1ps
`include "swwd_defines.svh"
module swwd_timebase (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Tick out
  swwd_link_if.timebase   lnk
);
  logic [7:0] div_reg;
  logic       tick_reg;
  wire        wrap = (div_reg == 8'(`SWWD_TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= wrap ? 8'h00 : div_reg + 8'h01;
      tick_reg <= wrap;
    end
  end

  assign lnk.tick = tick_reg;
endmodule

//--- core/swwd_top.sv
// Supply supervisor with window watchdog, core state machine
// Operation
// R1: After supply recovery, hold reset low for 25 ms before releasing high.
// R2: Drive reset low while filtered undervoltage reports supply below falling threshold.
// R3: Ignore undervoltage excursions shorter than the glitch filter time.
// R4: Release only if supply stays good for whole delay; undervoltage restarts it.
// R5: Timeout strap selects upper timeout of 0.25 s or 2.5 s.
// R6: Lower boundary is upper timeout divided by strap-selected ratio.
// R7: Capacitor mode: upper timeout is (units plus one) times 6.25 ms.
// R8: Early trigger with check on, or missing trigger by timeout, forces reset.
// R9: Host places each trigger between worst-case lower and upper boundaries.
// R10: First window after release has the lower-boundary check disabled.
// R11: First trigger after release enables the lower-boundary check.
// R12: Each accepted trigger clears window timers and starts a new window.
// R13: Host spaces trigger edges by more than 500 us.
// R14: Host software varies trigger timing and issues triggers from different places.
// R15: From power-up, reset output is held low until supply good and delay done.
// R16: Trigger rising edges are registered at the next internal clock cycle.
// R17: Only two states, running with reset high and reset with output low.
// R18: After watchdog fault, hold reset for release delay, then start first window.
`timescale 1ns/1ps
`include "swwd_defines.svh"
module swwd_top #(
  parameter logic [25:0] RELEASE_TICKS    = 26'(`SWWD_US_TO_TICKS(`SWWD_RELEASE_US)),
  parameter logic [25:0] TIMEOUT_LO_TICKS = 26'(`SWWD_US_TO_TICKS(`SWWD_TIMEOUT_LO_US)),
  parameter logic [25:0] TIMEOUT_HI_TICKS = 26'(`SWWD_US_TO_TICKS(`SWWD_TIMEOUT_HI_US)),
  parameter logic [25:0] CAP_STEP_TICKS   = 26'(`SWWD_US_TO_TICKS(`SWWD_CAP_STEP_US))
) (
  // Clock and power-up reset
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // Supply comparator
  input  wire logic                    below_falling,
  input  wire logic                    above_rising,
  // Straps and capacitor timing
  input  wire logic                    timeout_strap,
  input  wire logic                    ratio_strap,
  input  wire logic                    cap_mode,
  input  wire logic [`SWWD_CAPW-1:0]   cap_units,
  // Host trigger
  input  wire logic                    trigger_input,
  // Reset and status
  output logic                         reset_out_b,
  output logic                         early_fault,
  output logic                         late_fault,
  output logic                         lower_check_on
);

  function automatic logic [`SWWD_RECIPW-1:0] swwd_recip(input logic cap,
                                                         input logic wide,
                                                         input logic slow);
    logic [`SWWD_RECIPW-1:0] r;
    r = 12'h000;
    if (cap) begin
      r = wide ? 12'(`SWWD_RECIP(`SWWD_RATIO_WIDE_CP)) : 12'(`SWWD_RECIP(`SWWD_RATIO_NARROW_CP));
    end else if (slow) begin
      r = wide ? 12'(`SWWD_RECIP(`SWWD_RATIO_WIDE_HI)) : 12'(`SWWD_RECIP(`SWWD_RATIO_NARROW_HI));
    end else begin
      r = wide ? 12'(`SWWD_RECIP(`SWWD_RATIO_WIDE_LO)) : 12'(`SWWD_RECIP(`SWWD_RATIO_NARROW_LO));
    end
    return r;
  endfunction

  swwd_link_if lnk();

  swwd_timebase u_timebase (
    .clk   (clk),
    .rst_b (rst_b),
    .lnk   (lnk)
  );

  swwd_uv_filter u_uv_filter (
    .clk           (clk),
    .rst_b         (rst_b),
    .below_falling (below_falling),
    .above_rising  (above_rising),
    .lnk           (lnk)
  );

  swwd_pkg::swwd_state_type state_reg;
  swwd_pkg::swwd_state_type state_next;
  swwd_pkg::swwd_ticks_type win_cnt_reg;
  swwd_pkg::swwd_ticks_type win_cnt_next;
  swwd_pkg::swwd_ticks_type rel_cnt_reg;
  swwd_pkg::swwd_ticks_type rel_cnt_next;
  logic                     lb_en_reg;
  logic                     lb_en_next;
  logic                     trig_q_reg;
  logic                     edge_reg;

  // Window limits
  wire [`SWWD_TW-1:0]     cap_upper   = 26'(({14'h0000, cap_units} + 26'h1) * CAP_STEP_TICKS); // [R7]
  wire [`SWWD_TW-1:0]     upper_ticks = cap_mode ? cap_upper
                                      : (timeout_strap ? TIMEOUT_HI_TICKS : TIMEOUT_LO_TICKS); // [R5]
  wire [`SWWD_RECIPW-1:0] recip       = swwd_recip(cap_mode, ratio_strap, timeout_strap); // [R6]
  wire [37:0]             lower_prod  = 38'(upper_ticks) * 38'(recip);
  wire [`SWWD_TW-1:0]     lower_ticks = {4'h0, lower_prod[37:`SWWD_RECIP_SHIFT]}; // [R6]

  // Decisions
  wire running      = (state_reg == swwd_pkg::SWWD_ST_RUN);
  wire supply_good  = !lnk.uv_flt && above_rising;
  wire early_hit    = running && edge_reg && lb_en_reg && (win_cnt_reg < lower_ticks); // [R8]
  wire late_hit     = running && !edge_reg && (win_cnt_reg >= upper_ticks); // [R8]
  wire edge_ok      = running && edge_reg && !early_hit;
  wire to_reset     = running && (lnk.uv_flt || early_hit || late_hit); // [R2] [R17]
  wire rel_done     = !running && supply_good && lnk.tick
                      && (rel_cnt_reg >= RELEASE_TICKS - 26'h1); // [R1] [R4]

  assign state_next   = to_reset ? swwd_pkg::SWWD_ST_RESET
                      : (rel_done ? swwd_pkg::SWWD_ST_RUN : state_reg);
  assign rel_cnt_next = (running || !supply_good || rel_done) ? 26'h0 // [R4] [R18]
                      : (lnk.tick ? rel_cnt_reg + 26'h1 : rel_cnt_reg); // [R1]
  assign win_cnt_next = (!running || to_reset || edge_ok) ? 26'h0 // [R12]
                      : ((lnk.tick && win_cnt_reg < upper_ticks) ? win_cnt_reg + 26'h1
                         : win_cnt_reg);
  assign lb_en_next   = (!running || to_reset) ? 1'b0 // [R10] [R18]
                      : (edge_ok ? 1'b1 : lb_en_reg); // [R11]

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_q_reg <= 1'b0;
      edge_reg   <= 1'b0;
    end else begin
      trig_q_reg <= trigger_input;
      edge_reg   <= trigger_input && !trig_q_reg; // [R16]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg   <= swwd_pkg::SWWD_ST_RESET; // [R15]
      rel_cnt_reg <= 26'h0;
      win_cnt_reg <= 26'h0;
      lb_en_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      rel_cnt_reg <= rel_cnt_next;
      win_cnt_reg <= win_cnt_next;
      lb_en_reg   <= lb_en_next;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_out_b    <= 1'b0; // [R15]
      early_fault    <= 1'b0;
      late_fault     <= 1'b0;
      lower_check_on <= 1'b0;
    end else begin
      reset_out_b    <= (state_next == swwd_pkg::SWWD_ST_RUN); // [R17]
      early_fault    <= early_hit;
      late_fault     <= late_hit;
      lower_check_on <= lb_en_next;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence seq_held_low;
    !reset_out_b [*4];
  endsequence

  sequence seq_early_edge;
    running && edge_reg && lb_en_reg && (win_cnt_reg < lower_ticks);
  endsequence

  property prop_fault_holds;
    $fell(reset_out_b) |-> rel_cnt_reg == 26'h0 ##0 seq_held_low;
  endproperty

  AST_UV_RESET: assert property (running && lnk.uv_flt |=> !reset_out_b) // [R2]
    else $error("undervoltage did not force reset");

  AST_RELEASE_DELAY: assert property ($rose(reset_out_b) |-> // [R1]
    $past(rel_cnt_reg) == RELEASE_TICKS - 26'h1 && $past(supply_good) && $past(lnk.tick))
    else $error("reset released before the release delay");

  AST_DELAY_RESTART: assert property (!running && !supply_good |=> rel_cnt_reg == 26'h0) // [R4]
    else $error("release delay not restarted");

  AST_TIMEOUT_SELECT: assert property (!cap_mode |-> // [R5]
    upper_ticks == (timeout_strap ? TIMEOUT_HI_TICKS : TIMEOUT_LO_TICKS))
    else $error("wrong upper timeout for strap");

  AST_LOWER_RATIO: assert property (!cap_mode && !ratio_strap && !timeout_strap |-> // [R6]
    (32'(lower_ticks) + 32'h0000_0001) * 32 > 32'(upper_ticks)
    && 32'(lower_ticks) * 31 <= 32'(upper_ticks))
    else $error("lower boundary ratio out of range");

  AST_CAP_TIMEOUT: assert property (cap_mode |-> // [R7]
    upper_ticks == 26'((cap_units + 26'h1) * CAP_STEP_TICKS))
    else $error("capacitor timeout mismatch");

  AST_EARLY_FAULT: assert property (seq_early_edge |=> !reset_out_b && early_fault) // [R8]
    else $error("early trigger not faulted");

  AST_LATE_FAULT: assert property (running && !edge_reg && win_cnt_reg >= upper_ticks // [R8]
    |=> !reset_out_b && late_fault)
    else $error("missing trigger not faulted");

  AST_FIRST_WINDOW: assert property ($rose(reset_out_b) |-> !lb_en_reg ##1 !lower_check_on) // [R10]
    else $error("lower check active in first window");

  AST_NEW_WINDOW: assert property (edge_ok && !to_reset |=> // [R11] [R12]
    win_cnt_reg == 26'h0 && lb_en_reg && lower_check_on)
    else $error("accepted trigger did not restart window");

  AST_EDGE_SAMPLE: assert property (!trigger_input ##1 trigger_input |=> edge_reg) // [R16]
    else $error("trigger edge not registered");

  AST_TWO_STATES: assert property (reset_out_b == running) // [R17]
    else $error("reset output disagrees with state");

  AST_FAULT_HOLD: assert property (prop_fault_holds) // [R18]
    else $error("reset not held after fault");

endmodule

//--- core/swwd_uv_filter.sv
// Glitch filter and hysteresis hold on the undervoltage comparator
`timescale 1ns/1ps
`include "swwd_defines.svh"
module swwd_uv_filter (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Comparator levels
  input wire logic        below_falling,
  input wire logic        above_rising,
  // Filtered undervoltage
  swwd_link_if.filter     lnk
);
  logic [9:0] low_cnt_reg;
  logic       uv_reg;
  wire        low_full = (low_cnt_reg == 10'(`SWWD_GLITCH_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_reg <= 10'h000;
      uv_reg      <= 1'b1;
    end else begin
      low_cnt_reg <= !below_falling ? 10'h000 : (low_full ? low_cnt_reg : low_cnt_reg + 10'h001);
      if (below_falling && low_full) begin
        uv_reg <= 1'b1; // [R3]
      end else if (above_rising && !below_falling) begin
        uv_reg <= 1'b0;
      end
    end
  end

  assign lnk.uv_flt = uv_reg;

  AST_GLITCH_FILTER: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
    $rose(uv_reg) |-> $past(low_cnt_reg) == 10'(`SWWD_GLITCH_CYCLES - 1) && $past(below_falling))
    else $error("undervoltage passed before the glitch time");
endmodule

//--- sim/swwd_host_model.sv
// Host model that services the watchdog trigger
`timescale 1ns/1ps
module swwd_host_model (
  // Clock
  input wire logic clk,
  // Trigger out
  output logic     trigger_input
);
  int cyc;
  int rise_cyc;
  initial trigger_input = 1'b0;
  always @(posedge clk) begin
    cyc <= cyc + 1;
  end
  // Edge after a chosen count of 1 us ticks, spacing varied by caller
  task automatic pulse(input int ticks);
    @(posedge clk);
    repeat (ticks * 200) @(posedge clk);
    trigger_input <= 1'b1;
    rise_cyc = cyc;
    repeat (10) @(posedge clk);
    trigger_input <= 1'b0;
  endtask
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the supervisor window watchdog
`timescale 1ns/1ps
`include "swwd_defines.svh"
module tb_top;
  localparam int REL = 16;
  localparam int TLO = 128;
  localparam int THI = 256;
  localparam int CST = 16;
  logic                  clk = 1'b0;
  logic                  rst_b = 1'b0;
  logic                  below_falling = 1'b0;
  logic                  above_rising = 1'b1;
  logic                  timeout_strap = 1'b0;
  logic                  ratio_strap = 1'b0;
  logic                  cap_mode = 1'b0;
  logic [`SWWD_CAPW-1:0] cap_units = '0;
  logic                  trigger_input;
  logic                  reset_out_b;
  logic                  early_fault;
  logic                  late_fault;
  logic                  lower_check_on;
  int                    err_total = 0;
  int                    n_tests = 0;
  int                    n_early = 0;
  int                    n_late = 0;
  int                    n;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (early_fault === 1'b1) n_early <= n_early + 1;
    if (late_fault === 1'b1) n_late <= n_late + 1;
  end
  swwd_top #(.RELEASE_TICKS(26'(REL)), .TIMEOUT_LO_TICKS(26'(TLO)),
    .TIMEOUT_HI_TICKS(26'(THI)), .CAP_STEP_TICKS(26'(CST))) dut (
    .clk(clk), .rst_b(rst_b), .below_falling(below_falling), .above_rising(above_rising),
    .timeout_strap(timeout_strap), .ratio_strap(ratio_strap), .cap_mode(cap_mode),
    .cap_units(cap_units), .trigger_input(trigger_input), .reset_out_b(reset_out_b),
    .early_fault(early_fault), .late_fault(late_fault), .lower_check_on(lower_check_on));
  swwd_host_model host (.clk(clk), .trigger_input(trigger_input));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wait_rst(input logic lvl, input int lim);
    n = 0;
    while (reset_out_b !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  function automatic logic in_rng(input int v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction
  function automatic int lower(input int up, input int r);
    return (up * ((655360 + r / 2) / r)) >>> 16;
  endfunction
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // Full release delay, then first window again
  task automatic recover();
    wait_rst(1'b1, REL * 200 + 400);
    check("rel_time", in_rng(n, (REL - 1) * 200, REL * 200 + 8), 1);
    check("chk_off", lower_check_on, 0);
  endtask
  task automatic t_glitch();
    @(posedge clk);
    below_falling <= 1'b1;
    repeat (590) @(posedge clk);
    below_falling <= 1'b0;
    settle(20);
    check("glitch", reset_out_b, 1);
    @(posedge clk);
    below_falling <= 1'b1;
    above_rising <= 1'b0;
    wait_rst(1'b0, 700);
    check("uv_time", in_rng(n, 598, 606), 1);
    @(posedge clk);
    below_falling <= 1'b0;
    above_rising <= 1'b1;
    repeat (2000) @(posedge clk);
    above_rising <= 1'b0;
    repeat (300) @(posedge clk);
    above_rising <= 1'b1;
    #1;
    check("hold", reset_out_b, 0);
    recover();
  endtask
  task automatic t_win(input logic ts, input logic rs, input int ratio);
    int lw;
    int e0;
    lw = lower(ts ? THI : TLO, ratio);
    @(posedge clk);
    timeout_strap <= ts;
    ratio_strap <= rs;
    host.pulse(lw + 2);
    settle(4);
    check("accept", {reset_out_b, lower_check_on}, 2'b11);
    if (lw >= 2) begin
      e0 = n_early;
      host.pulse(lw - 2);
      wait_rst(1'b0, 20);
      settle(2);
      check("early", n_early - e0, 1);
      recover();
      host.pulse(1);
      settle(4);
      check("first", {reset_out_b, lower_check_on}, 2'b11);
    end
  endtask
  task automatic t_late(input int up);
    int l0;
    l0 = n_late;
    host.pulse(up / 8);
    wait_rst(1'b0, up * 200 + 400);
    settle(2);
    check("late_t", in_rng(host.cyc - host.rise_cyc, (up - 1) * 200, up * 200 + 12), 1);
    check("late", n_late - l0, 1);
    recover();
  endtask
  task automatic test_done();
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk);
    err_total++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check("por_low", reset_out_b, 0);
    recover();
    t_glitch();
    t_win(1'b0, 1'b1, 1249);
    t_win(1'b1, 1'b1, 1277);
    t_win(1'b0, 1'b0, 318);
    t_win(1'b1, 1'b0, 320);
    @(posedge clk);
    timeout_strap <= 1'b0;
    host.pulse(20);
    t_late(TLO);
    @(posedge clk);
    cap_mode <= 1'b1;
    cap_units <= 12'h003;
    t_late(4 * CST);
    test_done();
  end
endmodule
